/* inc/pac_pkg.sv */
/*
 * Shared constants for the pipelined converter output control block:
 * register map, field positions, reset values, pipeline slicing and modes.
 * Assumes a 32-bit AHB-Lite register bus and a single 20 MHz system clock.
 */
package pac_pkg;

   // Data path
   localparam int          DATA_WIDTH     = 14;
   localparam int          ANALOG_WIDTH   = 16;
   localparam int          LATENCY        = 6;
   localparam int          STAGE_COUNT    = 6;
   localparam int          STAGE_POS [6]  = '{11, 8, 6, 4, 2, 0};
   localparam int          STAGE_BITS [6] = '{3, 3, 2, 2, 2, 2};
   localparam logic signed [15:0] FULL_SCALE_MAX = 16'sh1FFF;
   localparam logic signed [15:0] FULL_SCALE_MIN = -16'sh2000;
   localparam logic [15:0] MIDSCALE       = 16'h2000;

   // Register byte offsets
   localparam logic [7:0] CTRL_OFFSET     = 8'h00;
   localparam logic [7:0] IRQ_STAT_OFFSET = 8'h04;
   localparam logic [7:0] IRQ_EN_OFFSET   = 8'h08;
   localparam logic [7:0] IRQ_CLR_OFFSET  = 8'h0C;
   localparam logic [7:0] SAMPLE_OFFSET   = 8'h10;
   localparam logic [7:0] STATE_OFFSET    = 8'h14;

   // Control register fields
   localparam int         CTRL_SHUTDOWN_SELECT_BIT   = 0;
   localparam int         CTRL_OE_N_BIT   = 1;
   localparam int         CTRL_MODE_LSB   = 2;
   localparam logic [3:0] CTRL_RESET      = 4'h2;

   // Interrupt bits
   localparam int         IRQ_WIDTH       = 2;
   localparam int         IRQ_WORD_BIT    = 0;
   localparam int         IRQ_OVR_BIT     = 1;

   // Sample register layout
   localparam int         SAMPLE_FLAG_BIT = 14;

   // Mode pin levels: ground, 1/3 supply, 2/3 supply, full supply
   localparam logic [1:0] MODE_GND        = 2'h0;
   localparam logic [1:0] MODE_THIRD      = 2'h1;
   localparam logic [1:0] MODE_TWO_THIRDS = 2'h2;
   localparam logic [1:0] MODE_SUPPLY     = 2'h3;

   // AHB encodings
   localparam logic [2:0] HSIZE_WORD      = 3'h2;

   typedef enum logic [3:0] {
      PAC_NORMAL     = 4'b0001,
      PAC_NORMAL_HIZ = 4'b0010,
      PAC_NAP        = 4'b0100,
      PAC_SLEEP      = 4'b1000
   } pac_power_type;

endpackage

/* rtl/pac_stage.sv */
/*
 * One converter pipeline stage: resolves its slice of the code from the
 * residue and merges it into the time-aligned partial word.
 * Assumes the caller advances all stages together and resets synchronously released.
 */
`timescale 1ns/1ps
module pac_stage
   import pac_pkg::*;
#(
   parameter int POS  = 0,
   parameter int BITS = 1
) (
   input  wire logic                  clk_sys,
   input  wire logic                  rst_n,
   input  wire logic                  advance,
   input  wire logic [DATA_WIDTH-1:0] code_in,
   input  wire logic [DATA_WIDTH-1:0] residue_in,
   input  wire logic                  flag_in,
   output logic      [DATA_WIDTH-1:0] code_out,
   output logic      [DATA_WIDTH-1:0] residue_out,
   output logic                       flag_out
);

   localparam logic [DATA_WIDTH-1:0] SLICE_MASK = DATA_WIDTH'((2 ** BITS - 1) << POS);

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         code_out    <= '0;
         residue_out <= '0;
         flag_out    <= 1'b0;
      end else if (advance) begin
         code_out    <= code_in | (residue_in & SLICE_MASK);
         residue_out <= residue_in & ~SLICE_MASK;
         flag_out    <= flag_in;
      end
   end

endmodule

/* rtl/pac_top.sv */
/*
 * Digital side of a 14-bit pipelined sampling converter: sample capture,
 * six-cycle pipeline, output format, power modes, AHB-Lite registers, interrupt.
 * Assumes analog_in is a digitised stand-in for the input, synchronous to clk_sys,
 * and a single AHB-Lite master with this slave alone on the bus.
 */
`timescale 1ns/1ps
module pac_top
   import pac_pkg::*;
(
   input  wire logic                    clk_sys,
   input  wire logic                    reset_n,
   input  wire logic [ANALOG_WIDTH-1:0] analog_in,
   input  wire logic                    hsel,
   input  wire logic [31:0]             haddr,
   input  wire logic [1:0]              htrans,
   input  wire logic                    hwrite,
   input  wire logic [2:0]              hsize,
   input  wire logic [31:0]             hwdata,
   input  wire logic                    hready,
   output logic      [31:0]             hrdata,
   output logic                         hreadyout,
   output logic                         hresp,
   output logic      [DATA_WIDTH-1:0]   sample_data_bus,
   output logic                         sample_data_oe_n,
   output logic                         overrange_flag,
   output logic                         overrange_oe_n,
   output logic                         dcs_enable,
   output logic                         irq
);

   logic                    rst_meta;
   logic                    rst_n;
   logic [3:0]              ctrl;
   logic [IRQ_WIDTH-1:0]    irq_stat;
   logic [IRQ_WIDTH-1:0]    irq_en;
   pac_power_type           power;
   pac_power_type           next_power;
   logic                    converting;
   logic                    twos_comp;
   logic [2:0]              fill;
   logic                    word_event;
   logic                    ovr_event;
   logic [IRQ_WIDTH-1:0]    clr_bits;
   logic                    wr_pend;
   logic [7:0]              wr_addr;
   logic                    addr_phase;
   logic [31:0]             next_rdata;
   logic signed [15:0]      held_in;
   logic                    in_over;
   logic [DATA_WIDTH-1:0]   in_code;
   logic [DATA_WIDTH-1:0]   code_chain [STAGE_COUNT+1];
   logic [DATA_WIDTH-1:0]   res_chain  [STAGE_COUNT+1];
   logic                    flag_chain [STAGE_COUNT+1];

   // Reset release through two flops
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   // Power mode from the shutdown and output enable bits
   always_comb begin
      unique case ({ctrl[CTRL_SHUTDOWN_SELECT_BIT], ctrl[CTRL_OE_N_BIT]})
         2'b00: next_power = PAC_NORMAL;
         2'b01: next_power = PAC_NORMAL_HIZ;
         2'b10: next_power = PAC_NAP;
         2'b11: next_power = PAC_SLEEP;
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         power <= PAC_NORMAL_HIZ;
      end else begin
         power <= next_power;
      end
   end

   assign converting = (power == PAC_NORMAL) || (power == PAC_NORMAL_HIZ);

   // Input capture: a synchronous model only sees the frozen value at the edge
   assign held_in = signed'(analog_in);
   assign in_over = (held_in > FULL_SCALE_MAX) || (held_in < FULL_SCALE_MIN);

   always_comb begin
      if (held_in > FULL_SCALE_MAX) begin
         in_code = {DATA_WIDTH{1'b1}};
      end else if (held_in < FULL_SCALE_MIN) begin
         in_code = '0;
      end else begin
         in_code = DATA_WIDTH'(analog_in + MIDSCALE);
      end
   end

   assign code_chain[0] = '0;
   assign res_chain[0]  = in_code;
   assign flag_chain[0] = in_over;

   // Stages hold still in nap and sleep, so the words frozen there come out first on wake
   generate
      for (genvar s = 0; s < STAGE_COUNT; s++) begin : g_stage
         pac_stage #(
            .POS  (STAGE_POS[s]),
            .BITS (STAGE_BITS[s])
         ) u_stage (
            .clk_sys     (clk_sys),
            .rst_n       (rst_n),
            .advance     (converting),
            .code_in     (code_chain[s]),
            .residue_in  (res_chain[s]),
            .flag_in     (flag_chain[s]),
            .code_out    (code_chain[s+1]),
            .residue_out (res_chain[s+1]),
            .flag_out    (flag_chain[s+1])
         );
      end
   endgenerate

   // Mode level decode
   assign twos_comp = (ctrl[CTRL_MODE_LSB +: 2] == MODE_TWO_THIRDS) ||
                      (ctrl[CTRL_MODE_LSB +: 2] == MODE_SUPPLY);

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         dcs_enable <= 1'b0;
      end else begin
         dcs_enable <= (ctrl[CTRL_MODE_LSB +: 2] == MODE_THIRD) ||
                       (ctrl[CTRL_MODE_LSB +: 2] == MODE_TWO_THIRDS);
      end
   end

   // Fill count: words only count once the pipe holds real samples
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         fill <= '0;
      end else if (converting && fill != 3'(LATENCY)) begin
         fill <= fill + 3'h1;
      end
   end

   // Output word register, the seventh flop level after the input edge
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         sample_data_bus <= '0;
         overrange_flag  <= 1'b0;
      end else if (converting) begin
         if (twos_comp) begin
            sample_data_bus <= {~code_chain[STAGE_COUNT][DATA_WIDTH-1],
                                code_chain[STAGE_COUNT][DATA_WIDTH-2:0]};
         end else begin
            sample_data_bus <= code_chain[STAGE_COUNT];
         end
         overrange_flag <= flag_chain[STAGE_COUNT];
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         sample_data_oe_n <= 1'b1;
         overrange_oe_n   <= 1'b1;
      end else begin
         sample_data_oe_n <= (power != PAC_NORMAL);
         overrange_oe_n   <= (power != PAC_NORMAL);
      end
   end

   assign word_event = converting && (fill == 3'(LATENCY));
   assign ovr_event  = word_event && flag_chain[STAGE_COUNT];

   // AHB-Lite slave, zero wait states
   assign addr_phase = hsel && hready && htrans[1];

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         wr_pend <= 1'b0;
         wr_addr <= '0;
      end else begin
         wr_pend <= addr_phase && hwrite && (hsize == HSIZE_WORD);
         wr_addr <= haddr[7:0];
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ctrl <= CTRL_RESET;
      end else if (wr_pend && wr_addr == CTRL_OFFSET) begin
         ctrl <= hwdata[3:0];
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         irq_en <= '0;
      end else if (wr_pend && wr_addr == IRQ_EN_OFFSET) begin
         irq_en <= hwdata[IRQ_WIDTH-1:0];
      end
   end

   assign clr_bits = (wr_pend && wr_addr == IRQ_CLR_OFFSET) ? hwdata[IRQ_WIDTH-1:0] : '0;

   // Set wins over a clear in the same cycle
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         irq_stat <= '0;
      end else begin
         irq_stat[IRQ_WORD_BIT] <= word_event | (irq_stat[IRQ_WORD_BIT] & ~clr_bits[IRQ_WORD_BIT]);
         irq_stat[IRQ_OVR_BIT]  <= ovr_event | (irq_stat[IRQ_OVR_BIT] & ~clr_bits[IRQ_OVR_BIT]);
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irq_stat & irq_en);
      end
   end

   // Read data fetched in the address phase so hrdata comes from a flop
   always_comb begin
      next_rdata = '0;
      unique case (haddr[7:0])
         CTRL_OFFSET:     next_rdata[3:0] = ctrl;
         IRQ_STAT_OFFSET: next_rdata[IRQ_WIDTH-1:0] = irq_stat;
         IRQ_EN_OFFSET:   next_rdata[IRQ_WIDTH-1:0] = irq_en;
         SAMPLE_OFFSET:   next_rdata[SAMPLE_FLAG_BIT:0] = {overrange_flag, sample_data_bus};
         STATE_OFFSET:    next_rdata[4:0] = {dcs_enable, power};
         default:         next_rdata = '0;
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         hrdata <= '0;
      end else if (addr_phase && !hwrite) begin
         hrdata <= next_rdata;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end

endmodule

/* tb/pac_top_assertions.sv */
/* Checker on the pac_top ports: latency, flag, pins, bus.
   Assumes hready is tied to hreadyout and a single bus master. */
`timescale 1ns/1ps
module pac_chk
   import pac_pkg::*;
(
   input wire logic                    clk_sys,
   input wire logic                    reset_n,
   input wire logic [ANALOG_WIDTH-1:0] analog_in,
   input wire logic                    hsel,
   input wire logic [31:0]             haddr,
   input wire logic [1:0]              htrans,
   input wire logic                    hwrite,
   input wire logic [31:0]             hrdata,
   input wire logic                    hreadyout,
   input wire logic                    hresp,
   input wire logic [DATA_WIDTH-1:0]   sample_data_bus,
   input wire logic                    sample_data_oe_n,
   input wire logic                    overrange_flag,
   input wire logic                    overrange_oe_n,
   input wire logic                    dcs_enable
);
   logic [3:0] run;
   logic       ctrl_wr;
   logic       rd_far;
   assign ctrl_wr = hsel && htrans[1] && hwrite && haddr[7:0] == CTRL_OFFSET;
   assign rd_far  = hsel && htrans[1] && !hwrite && haddr[7:0] >= 8'h20;
   // Fifteen driven cycles flush any word frozen by nap
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n)
         run <= 4'h0;
      else if (sample_data_oe_n)
         run <= 4'h0;
      else if (run != 4'hF)
         run <= run + 4'h1;
   end
   function automatic logic ovr(logic signed [15:0] v);
      return v > FULL_SCALE_MAX || v < FULL_SCALE_MIN;
   endfunction
   function automatic logic [12:0] low_code(logic signed [15:0] v);
      return v > FULL_SCALE_MAX ? 13'h1FFF : v < FULL_SCALE_MIN ? 13'h0000 : 13'(v + MIDSCALE);
   endfunction
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   sequence s_driving;
      run == 4'hF;
   endsequence
   chk_bus_okay: assert property (hreadyout && !hresp) else $error("bus answer not OKAY");
   chk_pipe_code: assert property (s_driving |->
      sample_data_bus[12:0] == low_code($past(analog_in, 7))) else $error("word mismatch");
   chk_flag_delay: assert property (s_driving |->
      overrange_flag == ovr($past(analog_in, 7))) else $error("flag mismatch");
   chk_flag_clamp: assert property (overrange_flag |->
      sample_data_bus[12:0] inside {13'h0000, 13'h1FFF}) else $error("flag without clamp");
   chk_pins_paired: assert property (sample_data_oe_n == overrange_oe_n)
      else $error("enables differ");
   chk_oe_cause: assert property ($changed(sample_data_oe_n) |-> $past(ctrl_wr, 4))
      else $error("enable moved without write");
   chk_dcs_cause: assert property ($changed(dcs_enable) |-> $past(ctrl_wr, 3))
      else $error("stabilizer moved without write");
   chk_far_read: assert property (rd_far |=> hrdata == 32'h0) else $error("unmapped read");
endmodule
bind pac_top pac_chk u_chk (.clk_sys, .reset_n, .analog_in, .hsel, .haddr, .htrans, .hwrite,
   .hrdata, .hreadyout, .hresp, .sample_data_bus, .sample_data_oe_n, .overrange_flag,
   .overrange_oe_n, .dcs_enable);

/* tb/pac_capture.sv */
/* Capture logic model: registers each word the converter drives.
   Assumes words mean something only while both enables are low. */
`timescale 1ns/1ps
module pac_capture
   import pac_pkg::*;
(
   input  wire logic                  clk_sys,
   input  wire logic [DATA_WIDTH-1:0] data_in,
   input  wire logic                  data_oe_n,
   input  wire logic                  flag_in,
   input  wire logic                  flag_oe_n,
   output logic                       cap_valid,
   output logic      [DATA_WIDTH:0]   cap_word
);
   // The word is latched every cycle; cap_valid marks those taken while both enables were low
   always_ff @(posedge clk_sys) begin
      cap_valid <= !data_oe_n && !flag_oe_n;
      cap_word  <= {flag_in, data_in};
   end
endmodule

/* tb/pipelined_adc_output_control_bench.sv */
/* Bench for pac_top: random samples, bus tasks, modes, power, interrupt.
   Assumes the checker is bound and the capture model sits on the pins. */
`timescale 1ns/1ps
module pipelined_adc_output_control_bench
   import pac_pkg::*;
;
   logic        clk_sys   = 1'b0;
   logic        reset_n   = 1'b0;
   logic [15:0] analog_in = 16'h0000;
   logic [15:0] next_analog;
   logic        hsel      = 1'b0;
   logic        hwrite    = 1'b0;
   logic [31:0] haddr     = 32'h0;
   logic [31:0] hwdata    = 32'h0;
   logic [1:0]  htrans    = 2'h0;
   logic [2:0]  hsize     = HSIZE_WORD;
   logic [31:0] hrdata;
   logic        hreadyout, hresp, sample_data_oe_n, overrange_flag, overrange_oe_n;
   logic        dcs_enable, irq, cap_valid;
   logic [13:0] sample_data_bus;
   logic [14:0] cap_word;
   logic [31:0] seed      = 32'h24C48E79;
   logic [1:0]  mode_sel  = 2'h0;
   logic [14:0] sq[$];
   logic [31:0] rq[$];
   logic [31:0] gq[$];
   int          bad_count = 0;
   int          checks    = 0;
   int          cycles    = 0;
   pac_top u_dut (.clk_sys, .reset_n, .analog_in, .hsel, .haddr, .htrans, .hwrite, .hsize,
      .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .sample_data_bus,
      .sample_data_oe_n, .overrange_flag, .overrange_oe_n, .dcs_enable, .irq);
   pac_capture u_cap (.clk_sys, .data_in(sample_data_bus), .data_oe_n(sample_data_oe_n),
      .flag_in(overrange_flag), .flag_oe_n(overrange_oe_n), .cap_valid, .cap_word);
   initial forever #25 clk_sys = ~clk_sys;
   function automatic logic [31:0] xs(logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction
   function automatic logic [14:0] exp_word(logic signed [15:0] v, logic [1:0] m);
      logic [13:0] c;
      c = v > FULL_SCALE_MAX ? 14'h3FFF : v < FULL_SCALE_MIN ? 14'h0000 : 14'(v + MIDSCALE);
      c[13] ^= m[1];
      return {v > FULL_SCALE_MAX || v < FULL_SCALE_MIN, c};
   endfunction
   task automatic note(logic [31:0] e, logic [31:0] g);
      rq.push_back(e);
      gq.push_back(g);
   endtask
   task automatic check(string what, logic [31:0] e, logic [31:0] g);
      checks++;
      if (e !== g) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic tick(int n);
      repeat (n) @(posedge clk_sys);
   endtask
   task automatic bus(logic w, logic [7:0] a, logic [31:0] d, logic [31:0] e);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      do @(posedge clk_sys); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      do @(posedge clk_sys); while (hreadyout !== 1'b1);
      if (!w)
         note(e, hrdata);
   endtask
   task automatic complete_run();
      if (bad_count == 0 && checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // Mostly in range, a quarter anywhere so clamping gets exercised
   always @(posedge clk_sys) begin
      seed = xs(seed);
      next_analog = seed[31:30] == 2'h0 ? seed[15:0] : {{2{seed[13]}}, seed[13:0]};
      analog_in <= next_analog;
      sq.push_back(exp_word(next_analog, mode_sel));
   end
   // Nine notes span drive, six stages, output and capture
   always @(negedge clk_sys) begin
      if (sq.size() >= 9) begin
         if (cap_valid === 1'b1)
            check("word", {17'h0, sq[0]}, {17'h0, cap_word});
         void'(sq.pop_front());
      end
      if (gq.size() != 0)
         check("pin or register", rq.pop_front(), gq.pop_front());
   end
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 5000) begin
         bad_count++;
         complete_run();
      end
   end
   initial begin
      tick(2);
      reset_n <= 1'b1;
      tick(12);
      bus(0, CTRL_OFFSET, 0, 32'h2);
      bus(0, STATE_OFFSET, 0, 32'h2);
      bus(0, 8'h20, 0, 32'h0);
      for (int m = 0; m < 4; m++) begin
         mode_sel = 2'(m);
         bus(1, CTRL_OFFSET, {28'h0, 2'(m), 2'h2}, 0);
         tick(12);
         bus(1, CTRL_OFFSET, {28'h0, 2'(m), 2'h0}, 0);
         tick(30);
         note(32'(m == 1 || m == 2), {31'h0, dcs_enable});
         bus(0, STATE_OFFSET, 0, {27'h0, m == 1 || m == 2, 4'h1});
         // Float before the format moves, so no driven word straddles the change
         bus(1, CTRL_OFFSET, {28'h0, 2'(m), 2'h2}, 0);
      end
      mode_sel = 2'h0;
      bus(1, CTRL_OFFSET, 32'h2, 0);
      tick(3);
      note(32'h1, {31'h0, sample_data_oe_n});
      bus(1, IRQ_EN_OFFSET, 32'h3, 0);
      tick(3);
      note(32'h1, {31'h0, irq});
      bus(1, IRQ_EN_OFFSET, 32'h0, 0);
      tick(3);
      note(32'h0, {31'h0, irq});
      bus(1, CTRL_OFFSET, 32'h1, 0);
      tick(3);
      note(32'h1, {31'h0, overrange_oe_n});
      bus(0, STATE_OFFSET, 0, 32'h4);
      bus(1, IRQ_CLR_OFFSET, 32'h3, 0);
      bus(1, IRQ_EN_OFFSET, 32'h3, 0);
      bus(0, IRQ_STAT_OFFSET, 0, 32'h0);
      note(32'h0, {31'h0, irq});
      bus(1, CTRL_OFFSET, 32'h3, 0);
      tick(3);
      bus(0, STATE_OFFSET, 0, 32'h8);
      note(32'h1, {31'h0, sample_data_oe_n});
      reset_n <= 1'b0;
      tick(2);
      reset_n <= 1'b1;
      tick(12);
      mode_sel = 2'h0;
      bus(0, CTRL_OFFSET, 0, 32'h2);
      bus(1, CTRL_OFFSET, 32'h0, 0);
      tick(30);
      complete_run();
   end
endmodule
